// ---- inc/rst_seq_pkg.sv ----
/*
 * Package for the reset stretch sequencer: timing constants, state codes
 * and the packed state carrier.
 * Assumes a 25 MHz system clock and a free-running 32 kHz slow clock pin.
 */
package rst_seq_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned POR_TIME_MS      = 300;
   localparam int unsigned SLOW_CLK_HZ      = 32000;
   localparam int unsigned POR_SLOW_CYCLES  = POR_TIME_MS * SLOW_CLK_HZ / 1000;
   localparam int unsigned SDRAM_STRETCH    = 7;
   localparam int unsigned SYS_STRETCH      = 14;
   localparam int unsigned QUAL_CYCLES      = 4;
   localparam int unsigned CNT_W            = 14;

   localparam logic [CNT_W-1:0] CNT_ZERO    = 14'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE     = 14'h0001;
   localparam logic [2:0]       QUAL_ZERO   = 3'h0;
   localparam logic [2:0]       QUAL_ONE    = 3'h1;

   // ***************************************************************
   // Sequencer states
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_POR     = 2'b00,
      ST_STRETCH = 2'b01,
      ST_RUN     = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic [1:0]       slow_sync;
      logic [1:0]       hard_sync;
      logic             slow_prev;
      seq_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic [2:0]       qual;
      logic             sdram_rst_n;
      logic             sys_rst_n;
      logic             rst_out_n;
   } seq_regs_t;

   localparam seq_regs_t REGS_RESET = '{
      slow_sync : 2'h0,
      hard_sync : 2'h0,
      slow_prev : 1'b0,
      state     : ST_POR,
      cnt       : CNT_ZERO,
      qual      : QUAL_ZERO,
      sdram_rst_n : 1'b0,
      sys_rst_n   : 1'b0,
      rst_out_n   : 1'b0
   };

endpackage

// ---- hdl/reset_stretch_sequencer.sv ----
/*
 * Reset stretch sequencer: internal power-on reset, qualified hard reset,
 * stretched SDRAM reset and stretched internal system reset.
 * Assumes i_rst_n is the board power-on reset and the slow clock and
 * hard-reset pins are asynchronous to i_clk_sys.
 */
`timescale 1ns/1ps

// Functional notes
// R1 - Hold power-on reset 300 ms of slow clock
// R2 - Stretch SDRAM reset by 7 slow cycles
// R3 - Stretch system reset 14 cycles, drive pin
// R4 - Hard reset held at least 4 slow cycles
// R5 - Qualify hard reset over 4 slow cycles
// R6 - Ignore short pulses; SDRAM released first
module reset_stretch_sequencer (
   // Clock and power-on reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // Pins
   input  wire logic i_slow_32k_clock,
   input  wire logic i_hard_reset_n,
   // Reset outputs, active low
   output logic      o_sdram_reset_n,
   output logic      o_internal_system_reset_n,
   output logic      o_reset_out_n
);

   // ***************************************************************
   // Local constants
   // ***************************************************************
   localparam int unsigned CNT_W = rst_seq_pkg::CNT_W;

   // Last count of the power-on hold before the stretch begins
   localparam logic [CNT_W-1:0] POR_LAST   = CNT_W'(rst_seq_pkg::POR_SLOW_CYCLES - 1);

   // Count at which the SDRAM reset is let go
   localparam logic [CNT_W-1:0] SDRAM_LAST = CNT_W'(rst_seq_pkg::SDRAM_STRETCH - 1);

   // Count at which the system reset and the pin are let go
   localparam logic [CNT_W-1:0] SYS_LAST   = CNT_W'(rst_seq_pkg::SYS_STRETCH - 1);

   // Qualifier value on the slow edge that accepts a hard reset
   localparam logic [2:0]       QUAL_LAST  = 3'(rst_seq_pkg::QUAL_CYCLES - 1);

   // Qualifier value while an accepted hard reset is still held
   localparam logic [2:0]       QUAL_FULL  = 3'(rst_seq_pkg::QUAL_CYCLES);

   // ***************************************************************
   // State
   // ***************************************************************
   rst_seq_pkg::seq_regs_t r_reg;
   rst_seq_pkg::seq_regs_t r_next;

   // ***************************************************************
   // Decoding helpers
   // ***************************************************************
   // Rising edge of the synchronised slow clock
   function automatic logic slow_edge(input rst_seq_pkg::seq_regs_t regs);
      logic seen;
      seen = regs.slow_sync[1] & ~regs.slow_prev;
      return seen;
   endfunction

   // Hard reset seen low after synchronisation
   function automatic logic hard_active(input rst_seq_pkg::seq_regs_t regs);
      logic low;
      low = ~regs.hard_sync[1];
      return low;
   endfunction

   // Hard resets are ignored until the power-on hold is over
   function automatic logic hard_allowed(input rst_seq_pkg::seq_regs_t regs);
      logic allowed;
      allowed = (regs.state != rst_seq_pkg::ST_POR);
      return allowed;
   endfunction

   // Qualifier compare
   function automatic logic qual_at(input rst_seq_pkg::seq_regs_t regs,
                                    input logic [2:0]              target);
      logic hit;
      hit = (regs.qual == target);
      return hit;
   endfunction

   // Stretch counter compare
   function automatic logic cnt_at(input rst_seq_pkg::seq_regs_t regs,
                                   input logic [CNT_W-1:0]        target);
      logic hit;
      hit = (regs.cnt == target);
      return hit;
   endfunction

   // Register image for an accepted hard reset: all resets on, stretch from zero
   function automatic rst_seq_pkg::seq_regs_t restart(input rst_seq_pkg::seq_regs_t regs);
      rst_seq_pkg::seq_regs_t img;
      img             = regs;
      img.state       = rst_seq_pkg::ST_STRETCH;
      img.cnt         = rst_seq_pkg::CNT_ZERO;
      img.sdram_rst_n = 1'b0;
      img.sys_rst_n   = 1'b0;
      img.rst_out_n   = 1'b0;
      return img;
   endfunction

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic slow_tick;
      logic hard_act;
      logic hard_ok;
      logic qual_take;
      logic qual_hold;
      slow_tick = 1'b0;
      hard_act  = 1'b0;
      hard_ok   = 1'b0;
      qual_take = 1'b0;
      qual_hold = 1'b0;
      r_next    = r_reg;

      // Two-stage synchronisers; only the second stage feeds logic
      r_next.slow_sync = {r_reg.slow_sync[0], i_slow_32k_clock};
      r_next.hard_sync = {r_reg.hard_sync[0], i_hard_reset_n};
      r_next.slow_prev = r_reg.slow_sync[1];

      slow_tick = slow_edge(r_reg);
      hard_act  = hard_active(r_reg);
      hard_ok   = hard_allowed(r_reg);
      qual_take = hard_ok & hard_act & slow_tick & qual_at(r_reg, QUAL_LAST);
      qual_hold = hard_ok & hard_act & qual_at(r_reg, QUAL_FULL);

      // ************************************************************
      // Hard-reset qualifier
      // ************************************************************
      // Counts slow edges with the hard reset low, cleared when it goes high
      if (!hard_act) begin
         r_next.qual = rst_seq_pkg::QUAL_ZERO;                        // [R6]
      end else if (slow_tick && !qual_at(r_reg, QUAL_FULL)) begin
         r_next.qual = r_reg.qual + rst_seq_pkg::QUAL_ONE;            // [R5]
      end

      // ************************************************************
      // Sequencer
      // ************************************************************
      case (r_reg.state)
         rst_seq_pkg::ST_POR: begin
            if (slow_tick) begin
               if (cnt_at(r_reg, POR_LAST)) begin
                  r_next.cnt   = rst_seq_pkg::CNT_ZERO;               // [R1]
                  r_next.state = rst_seq_pkg::ST_STRETCH;
               end else begin
                  r_next.cnt = r_reg.cnt + rst_seq_pkg::CNT_ONE;      // [R1]
               end
            end
         end
         rst_seq_pkg::ST_STRETCH: begin
            if (slow_tick) begin
               r_next.cnt = r_reg.cnt + rst_seq_pkg::CNT_ONE;
               // SDRAM comes out first, its stretch being the shorter
               if (cnt_at(r_reg, SDRAM_LAST)) begin
                  r_next.sdram_rst_n = 1'b1;                          // [R2] [R6]
               end
               if (cnt_at(r_reg, SYS_LAST)) begin
                  r_next.sys_rst_n = 1'b1;                            // [R3]
                  r_next.rst_out_n = 1'b1;                            // [R3]
                  r_next.state     = rst_seq_pkg::ST_RUN;
               end
            end
         end
         rst_seq_pkg::ST_RUN: begin
            r_next.cnt = rst_seq_pkg::CNT_ZERO;
         end
         default: begin
            r_next.state = rst_seq_pkg::ST_POR;
            r_next.cnt   = rst_seq_pkg::CNT_ZERO;
         end
      endcase

      // ************************************************************
      // Hard-reset restart
      // ************************************************************
      // An accepted hard reset asserts all three resets again
      if (qual_take) begin
         r_next = restart(r_next);                                    // [R5] [R4]
      end

      // The stretch does not start counting while the hard reset is held
      if (qual_hold) begin
         r_next.cnt = rst_seq_pkg::CNT_ZERO;
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= rst_seq_pkg::REGS_RESET;                            // [R1]
      end else begin
         r_reg <= r_next;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Each output is a register bit of its own, already active low
   assign o_sdram_reset_n           = r_reg.sdram_rst_n;
   assign o_internal_system_reset_n = r_reg.sys_rst_n;
   assign o_reset_out_n             = r_reg.rst_out_n;

endmodule

// ---- bench/rst_seq_asserts.sv ----
/* Checker for the reset stretch sequencer.
   Assumes it sees only the top ports and a slow clock that runs free. */
`timescale 1ns/1ps
module rst_seq_asserts (
   input wire logic i_clk_sys, i_rst_n, i_slow_32k_clock, i_hard_reset_n,
   input wire logic o_sdram_reset_n, o_internal_system_reset_n, o_reset_out_n
);
   logic slow_reg;
   int   edges_reg;
   // Raw slow edges since release, leading the design's synced count
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slow_reg  <= 1'b0;
         edges_reg <= 0;
      end else begin
         slow_reg <= i_slow_32k_clock;
         if (i_slow_32k_clock && !slow_reg) edges_reg <= edges_reg + 1;
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   a_por_hold: assert property (edges_reg <= rst_seq_pkg::POR_SLOW_CYCLES + 5
      |-> !o_sdram_reset_n) else $error("sdram reset left early");
   a_sdram_release: assert property (edges_reg == rst_seq_pkg::POR_SLOW_CYCLES + 8
      |-> o_sdram_reset_n) else $error("sdram reset held too long");
   a_sys_hold: assert property (edges_reg <= rst_seq_pkg::POR_SLOW_CYCLES + 12
      |-> !o_internal_system_reset_n) else $error("system reset left early");
   a_sys_release: assert property (edges_reg == rst_seq_pkg::POR_SLOW_CYCLES + 15
      |-> o_internal_system_reset_n) else $error("system reset held too long");
   a_pin_follows: assert property (o_reset_out_n == o_internal_system_reset_n)
      else $error("reset pin differs from system reset");
   a_sdram_first: assert property (!o_sdram_reset_n |-> !o_internal_system_reset_n)
      else $error("system reset left before sdram reset");
   a_hard_qualified: assert property (o_sdram_reset_n && i_hard_reset_n
      && $past(i_hard_reset_n, 4) |=> o_sdram_reset_n) else $error("reset without hard reset");
   a_stretch_gap: assert property ($rose(o_internal_system_reset_n)
      |-> $past(o_sdram_reset_n, 40)) else $error("stretch gap too short");
endmodule
bind reset_stretch_sequencer rst_seq_asserts u_rst_seq_asserts (.i_clk_sys, .i_rst_n,
   .i_slow_32k_clock, .i_hard_reset_n, .o_sdram_reset_n, .o_internal_system_reset_n,
   .o_reset_out_n);

// ---- bench/rst_src.sv ----
/* Board side: free slow clock, sped up, and the external hard-reset source.
   Assumes the bench calls pulse to press the hard reset. */
`timescale 1ns/1ps
module rst_src (
   output logic o_slow,
   output logic o_hard_n
);
   initial begin
      o_slow   = 1'b0;
      o_hard_n = 1'b1;
      forever #120 o_slow = ~o_slow;
   end
   // Low across exactly n slow rising edges
   task automatic pulse(input int n);
      @(negedge o_slow) o_hard_n = 1'b0;
      repeat (n) @(posedge o_slow);
      @(negedge o_slow) o_hard_n = 1'b1;
   endtask
endmodule

// ---- bench/test_reset_stretch_sequencer.sv ----
/* Testbench for the reset stretch sequencer.
   Assumes the board model of rst_src drives the slow clock and hard reset. */
`timescale 1ns/1ps
module test_reset_stretch_sequencer;
   logic i_clk_sys, i_rst_n, sdram_n, sys_n, pin_n;
   wire logic slow, hard_n;
   int fail_count, checks_done;
   reset_stretch_sequencer u_reset_stretch_sequencer (.i_clk_sys, .i_rst_n,
      .i_slow_32k_clock(slow), .i_hard_reset_n(hard_n), .o_sdram_reset_n(sdram_n),
      .o_internal_system_reset_n(sys_n), .o_reset_out_n(pin_n));
   rst_src u_rst_src (.o_slow(slow), .o_hard_n(hard_n));
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task check(input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: reset level", $time);
      end
   endtask
   task close_out;
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Past n slow edges, plus time for the synced release to land
   task slow_wait(input int n);
      repeat (n) @(posedge slow);
      #170;
   endtask
   task t_release(input int base);
      slow_wait(base + 6);
      check(sdram_n, 1'b0);
      slow_wait(1);
      check(sdram_n, 1'b1);
      check(sys_n, 1'b0);
      slow_wait(6);
      check(pin_n, 1'b0);
      slow_wait(1);
      check(sys_n, 1'b1);
      check(pin_n, 1'b1);
   endtask
   task t_short;
      u_rst_src.pulse(3);
      slow_wait(2);
      check(sdram_n, 1'b1);
   endtask
   task t_hard;
      u_rst_src.pulse(4);
      check(sys_n, 1'b0);
      t_release(0);
   endtask
   task t_rst;
      @(posedge i_clk_sys) #5 i_rst_n = 1'b0;
      #1 check(sdram_n, 1'b0);
      check(pin_n, 1'b0);
      repeat (2) @(posedge i_clk_sys);
      #5 i_rst_n = 1'b1;
      repeat (2) @(posedge i_clk_sys);
      #5 check(sdram_n, 1'b0);
      check(sys_n, 1'b0);
   endtask
   initial begin
      i_rst_n = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      #5 i_rst_n = 1'b1;
      t_release(rst_seq_pkg::POR_SLOW_CYCLES);
      t_short();
      t_hard();
      t_rst();
      close_out();
   end
   initial begin
      #4000000;
      fail_count++;
      close_out();
   end
endmodule
